// file: inc/hbd_pkg.sv
// Purpose: shared constants and carriers of the half-bridge sequencer
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   deadtime is the nominal figure, rounded up to whole cycles
package hbd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;     // 250 MHz
  localparam int DEADTIME_NS   = 1100;  // nominal deadtime interval
  localparam int DEADTIME_CYC  =
    (DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_W          = 9;     // counter width for deadtime

  // ---------------------------------------------------------------
  // comparator input positions in the synchroniser vector
  // ---------------------------------------------------------------
  localparam int IN_N          = 4;
  localparam int IN_SUPPLY     = 0;     // supply at start-up threshold
  localparam int IN_LOWER      = 1;     // ramp above lower threshold
  localparam int IN_UPPER      = 2;     // ramp above upper threshold
  localparam int IN_SHUTDOWN   = 3;     // node below shutdown threshold

  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_LOCK    = 6'h01,  // supply lockout
    ST_CHARGE  = 6'h02,  // ramp charging towards lower threshold
    ST_DT_LOW  = 6'h04,  // deadtime before low side
    ST_LOW_ON  = 6'h08,  // low side driven
    ST_DT_HIGH = 6'h10,  // deadtime before high side
    ST_HIGH_ON = 6'h20   // high side driven
  } hbd_state_e;

  localparam hbd_state_e RST_STATE = ST_LOCK;

  // ---------------------------------------------------------------
  // state carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DT_W-1:0] cnt;   // remaining deadtime cycles
    logic            done;  // one-cycle end-of-deadtime pulse
  } hbd_dt_s;

  typedef struct packed {
    logic [IN_N-1:0] sync1;    // first synchroniser stage
    logic [IN_N-1:0] sync2;    // second synchroniser stage
    hbd_state_e      state;
    logic            hs;       // high-side gate
    logic            ls;       // low-side gate
    logic            res_drv;  // timing resistor drive, 1 = high
    logic            boot;     // bootstrap switch enable
    logic            lock;     // lockout status
    logic            low_seen; // a low pulse happened since lockout
    logic [DT_W-1:0] off_cnt;  // cycles with both gates off
  } hbd_seq_s;

endpackage

// file: logic/hbd_deadtime.sv
// Purpose: deadtime interval timer for the half-bridge sequencer
// Assumes: start_i and abort_i come from logic on the same clock
// Notes:   done_o pulses once, DT_CYC+1 cycles after start_i
`timescale 1ns/1ps
module hbd_deadtime #(
  parameter int DT_CYC = hbd_pkg::DEADTIME_CYC
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // control
  input  wire logic start_i,
  input  wire logic abort_i,
  // status
  output logic      done_o
);

  hbd_pkg::hbd_dt_s dt_reg;
  hbd_pkg::hbd_dt_s dt_next;

  // ---------------------------------------------------------------
  // countdown; start wins over abort so a restart is never dropped
  // ---------------------------------------------------------------
  always_comb begin
    dt_next      = dt_reg;
    dt_next.done = 1'b0;
    if (start_i) begin
      dt_next.cnt = hbd_pkg::DT_W'(DT_CYC);
    end else if (abort_i) begin
      dt_next.cnt = '0;
    end else if (dt_reg.cnt != '0) begin
      dt_next.cnt  = dt_reg.cnt - 1'b1;
      dt_next.done = (dt_reg.cnt == hbd_pkg::DT_W'(1));
    end
  end

  // register stage
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dt_reg <= '0;
    end else begin
      dt_reg <= dt_next;
    end
  end

  assign done_o = dt_reg.done;

  // done is still low eight cycles after a start that runs on with no restart or abort
  property p_dt_len;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (start_i && !abort_i) ##1 (!start_i && !abort_i) [*8]
        |-> !done_o;
  endproperty
  a_dt_len: assert property (p_dt_len)
    else $error("deadtime ended too early");

endmodule

// file: logic/hbd_sequencer.sv
// Purpose: gate sequencing of a self-oscillating half-bridge driver
// Assumes: comparator levels arrive asynchronously from analog pins
// Notes:   all outputs registered; deadtime nominal, rounded up
//
// Behaviour
// - below start-up threshold both gate outputs stay low.
// - reaching start-up threshold ends lockout and starts alternation.
// - first gate pulse after lockout is always on the low side.
// - leaving lockout drives the timing resistor high to charge.
// - first lower-threshold crossing turns low side on after deadtime.
// - upper threshold: low off, resistor low, deadtime, then high on.
// - falling to lower threshold: high off, resistor high, then low on.
// - deadtime between one gate off and the other on is 1.1 us.
// - node below shutdown threshold stops oscillation, gates off.
// - shutdown releases itself once the ramp reaches lower threshold.
// - during lockout the timing resistor drive is held low.
`timescale 1ns/1ps
module hbd_sequencer #(
  parameter int DT_CYC = hbd_pkg::DEADTIME_CYC
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // comparator levels from the analog front end
  input  wire logic supply_good_i,
  input  wire logic ramp_above_lower_i,
  input  wire logic ramp_above_upper_i,
  input  wire logic node_below_shutdown_i,
  // gate drives
  output logic      high_side_gate_out_o,
  output logic      low_side_gate_out_o,
  // timing network and bootstrap
  output logic      timing_resistor_drive_o,
  output logic      bootstrap_en_o,
  // status
  output logic      supply_lockout_state_o
);

  hbd_pkg::hbd_seq_s st_reg;
  hbd_pkg::hbd_seq_s st_next;
  logic              dt_done;
  logic              dt_start;
  logic              dt_abort;
  logic              supply_ok;
  logic              above_lower;
  logic              above_upper;
  logic              shutdown;

  // ---------------------------------------------------------------
  // synchronised comparator levels, read only from the second stage
  // ---------------------------------------------------------------
  assign supply_ok   = st_reg.sync2[hbd_pkg::IN_SUPPLY];
  assign above_lower = st_reg.sync2[hbd_pkg::IN_LOWER];
  assign above_upper = st_reg.sync2[hbd_pkg::IN_UPPER];
  assign shutdown    = st_reg.sync2[hbd_pkg::IN_SHUTDOWN];

  // ---------------------------------------------------------------
  // deadtime timer
  // ---------------------------------------------------------------
  hbd_deadtime #(
    .DT_CYC (DT_CYC)
  ) u_deadtime (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (dt_start),
    .abort_i   (dt_abort),
    .done_o    (dt_done)
  );

  // ---------------------------------------------------------------
  // next-state logic; lockout beats shutdown beats ramp events
  // ---------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = {node_below_shutdown_i, ramp_above_upper_i,
                     ramp_above_lower_i, supply_good_i};
    st_next.sync2 = st_reg.sync1;
    dt_start      = 1'b0;
    dt_abort      = 1'b0;
    if (!supply_ok) begin
      st_next.state = hbd_pkg::ST_LOCK;
      dt_abort      = 1'b1;
    end else if (shutdown && st_reg.state != hbd_pkg::ST_LOCK) begin
      // not latched: restart only through the normal ramp path
      st_next.state = hbd_pkg::ST_CHARGE;
      dt_abort      = 1'b1;
    end else begin
      case (st_reg.state)
        hbd_pkg::ST_LOCK: begin
          st_next.state = hbd_pkg::ST_CHARGE;
        end
        hbd_pkg::ST_CHARGE: begin
          if (above_lower) begin
            st_next.state = hbd_pkg::ST_DT_LOW;
            dt_start      = 1'b1;
          end
        end
        hbd_pkg::ST_DT_LOW: begin
          if (dt_done) begin
            st_next.state = hbd_pkg::ST_LOW_ON;
          end
        end
        hbd_pkg::ST_LOW_ON: begin
          if (above_upper) begin
            st_next.state = hbd_pkg::ST_DT_HIGH;
            dt_start      = 1'b1;
          end
        end
        hbd_pkg::ST_DT_HIGH: begin
          if (dt_done) begin
            st_next.state = hbd_pkg::ST_HIGH_ON;
          end
        end
        hbd_pkg::ST_HIGH_ON: begin
          if (!above_lower) begin
            st_next.state = hbd_pkg::ST_DT_LOW;
            dt_start      = 1'b1;
          end
        end
        default: begin
          st_next.state = hbd_pkg::ST_LOCK;
          dt_abort      = 1'b1;
        end
      endcase
    end
    // outputs decoded from the next state so they leave a flip-flop
    st_next.ls   = (st_next.state == hbd_pkg::ST_LOW_ON);
    st_next.hs   = (st_next.state == hbd_pkg::ST_HIGH_ON);
    st_next.boot = st_next.ls;
    st_next.lock = (st_next.state == hbd_pkg::ST_LOCK);
    // resistor low in lockout and while discharging towards lower
    st_next.res_drv = !(st_next.lock ||
                     st_next.state == hbd_pkg::ST_DT_HIGH ||
                     st_next.state == hbd_pkg::ST_HIGH_ON);
    // checking helpers
    st_next.low_seen = !st_next.lock && (st_reg.low_seen || st_next.ls);
    if (st_reg.ls || st_reg.hs) begin
      st_next.off_cnt = '0;
    end else if (st_reg.off_cnt != '1) begin
      st_next.off_cnt = st_reg.off_cnt + 1'b1;
    end
  end

  // register stage; reset leaves the driver in lockout, gates off
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg         <= '0;
      st_reg.state   <= hbd_pkg::RST_STATE;
      st_reg.lock    <= 1'b1;
      st_reg.off_cnt <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign high_side_gate_out_o    = st_reg.hs;
  assign low_side_gate_out_o     = st_reg.ls;
  assign timing_resistor_drive_o = st_reg.res_drv;
  assign bootstrap_en_o          = st_reg.boot;
  assign supply_lockout_state_o  = st_reg.lock;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_lock_off;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !supply_ok |=> !st_reg.hs && !st_reg.ls && !st_reg.res_drv;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("gate or resistor active in lockout");

  property p_start;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (st_reg.lock && supply_ok && !shutdown)
        |=> st_reg.res_drv ##1 !st_reg.hs;
  endproperty
  a_start: assert property (p_start)
    else $error("no charging after lockout released");

  property p_boot;
    @(posedge mclk_i) disable iff (sys_rst_i)
      st_reg.boot == st_reg.ls;
  endproperty
  a_boot: assert property (p_boot)
    else $error("bootstrap switch not tied to low side");

  property p_first_low;
    @(posedge mclk_i) disable iff (sys_rst_i)
      st_reg.hs |-> st_reg.low_seen;
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("high side pulsed before any low pulse");

  property p_deadtime;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ($rose(st_reg.ls) || $rose(st_reg.hs))
        |-> st_reg.off_cnt >= hbd_pkg::DT_W'(DT_CYC);
  endproperty
  a_deadtime: assert property (p_deadtime)
    else $error("deadtime shorter than interval");

  property p_upper;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (st_reg.ls && above_upper && supply_ok)
        |=> !st_reg.ls && !st_reg.res_drv;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper threshold did not end low pulse");

  property p_lower;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (st_reg.hs && !above_lower && supply_ok)
        |=> !st_reg.hs && st_reg.res_drv;
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower threshold did not end high pulse");

  property p_shutdown;
    @(posedge mclk_i) disable iff (sys_rst_i)
      shutdown |=> !st_reg.ls && !st_reg.hs && !st_reg.boot;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("gate active during shutdown");

  property p_resume;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (st_reg.state == hbd_pkg::ST_CHARGE && supply_ok && !shutdown
        && above_lower) |=> st_reg.state == hbd_pkg::ST_DT_LOW;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no restart after shutdown release");

  property p_exclusive;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !(st_reg.hs && st_reg.ls);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("both gates on together");

endmodule

// file: bench/hbd_bridge_model.sv
// Purpose: half-bridge timing network seen by the sequencer
// Assumes: one ramp step per clock, thresholds at 1/3, 2/3, 1/6 of top
// Notes:   no comparator hysteresis; a pull-down beats the resistor drive
`timescale 1ns/1ps
module hbd_bridge_model #(
  parameter int TOP = 60
) (
  // clock
  input  wire logic mclk_i,
  // timing resistor drive and external pull-down
  input  wire logic timing_resistor_drive_i,
  input  wire logic hold_low_i,
  // comparator levels
  output logic      ramp_above_lower_o,
  output logic      ramp_above_upper_o,
  output logic      node_below_shutdown_o
);
  // ---------------------------------------------------------------
  // capacitor ramp
  // ---------------------------------------------------------------
  int level_reg = 0;

  // charges while driven high, discharges while driven low
  always_ff @(posedge mclk_i) begin
    if (hold_low_i) begin
      level_reg <= 0;
    end else if (timing_resistor_drive_i && level_reg < TOP) begin
      level_reg <= level_reg + 1;
    end else if (!timing_resistor_drive_i && level_reg > 0) begin
      level_reg <= level_reg - 1;
    end
  end

  // threshold comparators
  assign ramp_above_lower_o    = level_reg >= TOP / 3;
  assign ramp_above_upper_o    = level_reg >= TOP * 2 / 3;
  assign node_below_shutdown_o = level_reg < TOP / 6;
endmodule

// file: bench/tb.sv
// Purpose: self-checking bench of the half-bridge sequencer
// Assumes: short deadtime parameter so the run stays small
// Notes:   outputs sampled on the falling edge where they are settled
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam int DT    = 10;
  localparam int LIMIT = 500;
  localparam int S_HI  = 0;
  localparam int S_LOW = 1;
  localparam int S_LK  = 2;
  localparam int S_ANY = 3;
  logic mclk_i = 1'b0;
  logic sys_rst_i;
  logic supply_good;
  logic hold_low;
  logic above_lower;
  logic above_upper;
  logic below_sd;
  logic hs;
  logic ls;
  logic res_drv;
  logic boot;
  logic lock;
  int   miscompares = 0;
  int   checked     = 0;
  int   n;

  hbd_sequencer #(.DT_CYC(DT)) i_dut (
    .mclk_i                  (mclk_i),
    .sys_rst_i               (sys_rst_i),
    .supply_good_i           (supply_good),
    .ramp_above_lower_i      (above_lower),
    .ramp_above_upper_i      (above_upper),
    .node_below_shutdown_i   (below_sd),
    .high_side_gate_out_o    (hs),
    .low_side_gate_out_o     (ls),
    .timing_resistor_drive_o (res_drv),
    .bootstrap_en_o          (boot),
    .supply_lockout_state_o  (lock)
  );

  hbd_bridge_model i_net (
    .mclk_i                  (mclk_i),
    .timing_resistor_drive_i (res_drv),
    .hold_low_i              (hold_low),
    .ramp_above_lower_o      (above_lower),
    .ramp_above_upper_o      (above_upper),
    .node_below_shutdown_o   (below_sd)
  );

  // 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic sig(input int s);
    case (s)
      S_HI:    return hs;
      S_LOW:   return ls;
      S_LK:    return lock;
      default: return hs | ls;
    endcase
  endfunction

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", name, e, g);
    end
  endtask

  // range check of a counted interval; the count is printed only when out of range
  task automatic chk_rng(input string name, input int min_v,
                         input int max_v, input int got);
    checked++;
    if (got < min_v || got > max_v) begin
      miscompares++;
      $display("FAIL %s expected %0d..%0d seen %0d", name, min_v, max_v, got);
    end
  endtask

  // counts falling edges until the chosen output reaches v
  task automatic wait_sig(input int s, input logic v, output int cnt);
    cnt = 0;
    while (sig(s) !== v) begin
      @(negedge mclk_i);
      cnt++;
      if (cnt > LIMIT) begin
        miscompares++;
        $display("FAIL wait %0d expected %b seen %b", s, v, sig(s));
        results();
      end
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_lockout();
    repeat (5) @(negedge mclk_i);
    chk("hs", 1'b0, hs);
    chk("ls", 1'b0, ls);
    chk("resistor", 1'b0, res_drv);
    chk("lock", 1'b1, lock);
    @(posedge mclk_i);
    supply_good <= 1'b1;
    wait_sig(S_LK, 1'b0, n);
    chk("resistor", 1'b1, res_drv);
    chk("gates", 1'b0, hs | ls);
    $display("test lockout done");
  endtask

  // the first pulse must be low side, with the bootstrap on
  task automatic t_first();
    wait_sig(S_ANY, 1'b1, n);
    chk("ls", 1'b1, ls);
    chk("hs", 1'b0, hs);
    chk("boot", 1'b1, boot);
    $display("test first pulse done");
  endtask

  // off interval both ways; allows for the rounding of the timer
  task automatic t_deadtime();
    wait_sig(S_LOW, 1'b0, n);
    chk("resistor", 1'b0, res_drv);
    wait_sig(S_HI, 1'b1, n);
    chk_rng("low to high", DT + 1, DT + 2, n);
    chk("resistor", 1'b0, res_drv);
    chk("boot", 1'b0, boot);
    wait_sig(S_HI, 1'b0, n);
    chk("resistor", 1'b1, res_drv);
    wait_sig(S_LOW, 1'b1, n);
    chk_rng("high to low", DT + 1, DT + 2, n);
    chk("boot", 1'b1, boot);
    $display("test deadtime done");
  endtask

  // pull the node down while the low side is on, then let go
  task automatic t_shutdown();
    wait_sig(S_LOW, 1'b1, n);
    @(posedge mclk_i);
    hold_low <= 1'b1;
    wait_sig(S_ANY, 1'b0, n);
    chk_rng("stop delay", 1, 5, n);
    repeat (30) begin
      @(negedge mclk_i);
      chk("gates", 1'b0, hs | ls);
      chk("boot", 1'b0, boot);
    end
    @(posedge mclk_i);
    hold_low <= 1'b0;
    wait_sig(S_ANY, 1'b1, n);
    chk("ls", 1'b1, ls);
    $display("test shutdown done");
  endtask

  // supply drops while the high side is on, then returns
  task automatic t_brownout();
    wait_sig(S_HI, 1'b1, n);
    @(posedge mclk_i);
    supply_good <= 1'b0;
    wait_sig(S_ANY, 1'b0, n);
    chk_rng("off delay", 1, 4, n);
    repeat (4) @(negedge mclk_i);
    chk("lock", 1'b1, lock);
    chk("resistor", 1'b0, res_drv);
    @(posedge mclk_i);
    supply_good <= 1'b1;
    wait_sig(S_ANY, 1'b1, n);
    chk("ls", 1'b1, ls);
    chk("hs", 1'b0, hs);
    $display("test brownout done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst_i   = 1'b1;
    supply_good = 1'b0;
    hold_low    = 1'b0;
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_lockout();
    t_first();
    t_deadtime();
    t_shutdown();
    t_brownout();
    results();
  end
endmodule
